// file: hdl/async_serial_channel.sv
`timescale 1ns/100ps
`default_nettype none

module tx_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, empty_q, do_wr, do_rd;

  assign do_wr = in_valid_i && !full_q;
  assign do_rd = out_ready_i && !empty_q;
  assign in_ready_o = !full_q;
  assign out_valid_o = !empty_q;
  assign out_data_o = mem_q[rp_q];
  assign cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);

  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (do_wr) begin
        wp_q <= (wp_q == LAST_C) ? '0 : wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= (rp_q == LAST_C) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      full_q <= (cnt_d == DEPTH_C);
      empty_q <= (cnt_d == '0);
    end
  end
endmodule : tx_word_fifo

module async_serial_channel (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration registers
  input wire logic [7:0] mode_format_reg_i,
  input wire logic [7:0] tx_config_reg_i,
  input wire logic [7:0] rx_config_reg_i,
  input wire logic [7:0] irq_config_reg_i,
  input wire logic xtal_en_i,
  input wire logic dma_req_sel_i,
  input wire logic error_reset_i,
  // Transmit data
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // Receive data
  output logic [7:0] rx_data_o,
  input wire logic rx_pop_i,
  // Status
  output logic [7:0] line_status_reg_o,
  output logic [7:0] rx_error_status_reg_o,
  output logic special_rx_o,
  // Serial and modem pins
  output logic txd_o,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  input wire logic carrier_detect_pin_n_i,
  input wire logic sync_n_i,
  output logic rts_n_o,
  output logic dtr_req_n_o
);
  import async_serial_pkg::*;

  logic [3:0] pin_m_q, pin_s_q;
  logic rxd_s, cts_s, dcd_s, sync_s, rxd_d_q;
  logic async_mode, auto_en, tx_en, rx_en;
  logic [7:0] fac, stop_len, tx_lim, hlim;
  logic [1:0] stop_code;

  // Every pin passes two flops before use
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_m_q <= 4'hf;
      pin_s_q <= 4'hf;
      rxd_d_q <= 1'b1;
    end else begin
      pin_m_q <= {sync_n_i, carrier_detect_pin_n_i, cts_n_i, rxd_i};
      pin_s_q <= pin_m_q;
      rxd_d_q <= pin_s_q[0];
    end
  end
  assign {sync_s, dcd_s, cts_s, rxd_s} = pin_s_q;

  assign stop_code = mode_format_reg_i[MF_STOP_LO+:2];
  assign async_mode = (stop_code != STOP_SYNC); // see R23
  assign auto_en = rx_config_reg_i[RC_AUTO];
  assign tx_en = async_mode && tx_config_reg_i[TC_TX_EN] && !(auto_en && cts_s); // see R10
  assign rx_en = async_mode && rx_config_reg_i[RC_RX_EN] && !(auto_en && dcd_s); // see R21
  assign fac = factor_cycles(mode_format_reg_i[MF_CF_LO+:2]); // see R6
  assign hlim = (fac >> 1) - 8'h01;

  // A 1x factor has no half cell, so a stray 1.5 setting falls back to one bit
  always_comb begin
    case (stop_code)
      STOP_ONE: stop_len = fac;
      STOP_ONE_HALF: stop_len = (fac == 8'h01) ? fac : fac + (fac >> 1); // see R7
      default: stop_len = fac << 1;
    endcase
  end

  // Transmit buffer
  logic [7:0] txf_data;
  logic txf_valid, tx_pop;

  tx_word_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(txf_data),
    .out_valid_o(txf_valid),
    .out_ready_i(tx_pop)
  );

  // Transmitter
  ser_state_t tx_st_q;
  logic [7:0] tx_cnt_q, tx_sh_q, tx_mask;
  logic [3:0] tx_idx_q, tx_n_q, tx_n;
  logic tx_par_q, tx_bnd, tx_go, tx_bit, brk_q, all_sent_q, rts_hold_q;
  logic [1:0] tx_len;

  assign tx_len = tx_config_reg_i[TC_LEN_LO+:2]; // see R2
  always_comb begin
    tx_n = len_bits(tx_len);
    if (tx_len == 2'h0) begin // see R3
      if (txf_data[7:1] == 7'h78) begin
        tx_n = 4'h1;
      end else if (txf_data[7:2] == 6'h38) begin
        tx_n = 4'h2;
      end else if (txf_data[7:3] == 5'h18) begin
        tx_n = 4'h3;
      end else if (txf_data[7:4] == 4'h8) begin
        tx_n = 4'h4;
      end
    end
  end
  assign tx_mask = len_mask(tx_n);
  assign tx_lim = (tx_st_q == ST_STOP) ? stop_len : fac;
  assign tx_bnd = (tx_cnt_q == tx_lim - 8'h01);
  assign tx_go = tx_en && txf_valid;
  assign tx_pop = tx_bnd && tx_go && (tx_st_q == ST_IDLE || tx_st_q == ST_STOP); // see R1

  // Free-running in idle so break still lands on bit boundaries
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_q <= 8'h00;
    end else begin
      tx_cnt_q <= tx_bnd ? 8'h00 : tx_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q <= ST_IDLE;
      tx_sh_q <= 8'h00;
      tx_idx_q <= 4'h0;
      tx_n_q <= 4'h0;
      tx_par_q <= 1'b0;
    end else if (tx_bnd) begin
      case (tx_st_q)
        ST_IDLE, ST_STOP: begin
          if (tx_go) begin
            tx_st_q <= ST_START;
            tx_sh_q <= txf_data & tx_mask;
            tx_n_q <= tx_n;
            tx_par_q <= ^(txf_data & tx_mask) ^ !mode_format_reg_i[MF_PAR_EVEN]; // see R5
          end else begin
            tx_st_q <= ST_IDLE;
          end
        end
        ST_START: begin
          tx_st_q <= ST_DATA;
          tx_idx_q <= 4'h0;
        end
        ST_DATA: begin
          tx_sh_q <= tx_sh_q >> 1;
          tx_idx_q <= tx_idx_q + 4'h1;
          if (tx_idx_q == tx_n_q - 4'h1) begin
            tx_st_q <= mode_format_reg_i[MF_PAR_EN] ? ST_PARITY : ST_STOP; // see R5
          end
        end
        ST_PARITY: tx_st_q <= ST_STOP;
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    case (tx_st_q)
      ST_START: tx_bit = 1'b0;
      ST_DATA: tx_bit = tx_sh_q[0];
      ST_PARITY: tx_bit = tx_par_q;
      default: tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_q <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      if (tx_bnd) begin
        brk_q <= tx_config_reg_i[TC_BRK]; // see R11
      end
      txd_o <= brk_q ? 1'b0 : tx_bit; // see R11
    end
  end

  // Pin lags state by one flop, so all-sent lags by the same amount
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      all_sent_q <= 1'b1;
      rts_hold_q <= 1'b0;
      rts_n_o <= 1'b1;
      dtr_req_n_o <= 1'b1;
    end else begin
      all_sent_q <= !txf_valid && (tx_st_q == ST_IDLE); // see R12
      rts_hold_q <= tx_config_reg_i[TC_RTS] || (rts_hold_q && !all_sent_q); // see R9
      rts_n_o <= !(tx_config_reg_i[TC_RTS] ||
                   (auto_en && rts_hold_q && !all_sent_q)); // see R8 see R9
      dtr_req_n_o <= dma_req_sel_i ? !tx_ready_o : !tx_config_reg_i[TC_DTR]; // see R20
    end
  end

  // Receiver
  ser_state_t rx_st_q;
  logic [7:0] rx_cnt_q, rx_word, rx_word_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_idx_q, rx_n, rx_total;
  logic rx_xor_q, rx_smp, rx_fe, rx_pe, rx_null, rx_brk_q;
  logic rx_push_q, rx_fe_q, rx_pe_q;

  assign rx_n = len_bits(rx_config_reg_i[RC_LEN_LO+:2]); // see R14
  assign rx_total = rx_n + 4'(mode_format_reg_i[MF_PAR_EN]);
  assign rx_smp = (rx_cnt_q == fac - 8'h01);
  assign rx_word = (rx_total == 4'h9) ? rx_sh_q[7:0] :
                   8'(rx_sh_q >> (4'h9 - rx_total)); // see R17
  assign rx_fe = !rxd_s; // see R15
  assign rx_pe = mode_format_reg_i[MF_PAR_EN] &&
                 (rx_xor_q ^ !mode_format_reg_i[MF_PAR_EVEN]);
  assign rx_null = ((rx_word & len_mask(rx_n)) == 8'h00);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= 8'h00;
      rx_sh_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_xor_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= 8'h00;
      rx_fe_q <= 1'b0;
      rx_pe_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (rx_brk_q && rxd_s) begin
        rx_brk_q <= 1'b0; // see R22
      end
      if (!rx_en) begin
        rx_st_q <= ST_IDLE;
      end else begin
        case (rx_st_q)
          ST_IDLE: begin
            rx_cnt_q <= 8'h00;
            rx_idx_q <= 4'h0;
            rx_xor_q <= 1'b0;
            if (!rx_brk_q && rxd_d_q && !rxd_s) begin
              rx_st_q <= (fac == 8'h01) ? ST_DATA : ST_START;
            end
          end
          ST_START: begin
            if (rx_cnt_q == hlim) begin
              rx_cnt_q <= 8'h00;
              rx_st_q <= rxd_s ? ST_IDLE : ST_DATA; // see R24
            end else begin
              rx_cnt_q <= rx_cnt_q + 8'h01;
            end
          end
          ST_DATA: begin
            if (rx_smp) begin // see R24
              rx_cnt_q <= 8'h00;
              rx_sh_q <= {rxd_s, rx_sh_q[8:1]};
              rx_xor_q <= rx_xor_q ^ rxd_s;
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_total - 4'h1) begin
                rx_st_q <= ST_STOP;
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 8'h01;
            end
          end
          ST_STOP: begin
            if (rx_smp) begin
              rx_st_q <= ST_IDLE;
              rx_word_q <= rx_word;
              rx_pe_q <= rx_pe;
              if (rx_null && rx_fe) begin // see R22
                rx_brk_q <= 1'b1;
                rx_push_q <= !rx_brk_q;
                rx_fe_q <= 1'b0;
              end else begin
                rx_push_q <= 1'b1;
                rx_fe_q <= rx_fe; // see R15
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 8'h01;
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Receive FIFO, entry 0 is the head; layout {parity err, framing err, data}
  logic [9:0] rxq_q [RX_FIFO_DEPTH];
  logic [1:0] rxq_cnt_q, rxq_wp;
  logic rxq_pop, rxq_push, pe_lat_q, ovr_lat_q;

  assign rxq_pop = rx_pop_i && (rxq_cnt_q != 2'h0);
  assign rxq_push = rx_push_q && (rxq_cnt_q != 2'(RX_FIFO_DEPTH) || rxq_pop);
  assign rxq_wp = rxq_pop ? rxq_cnt_q - 2'h1 : rxq_cnt_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
        rxq_q[i] <= 10'h000;
      end
      rxq_cnt_q <= 2'h0;
    end else begin
      for (int i = 0; i < RX_FIFO_DEPTH - 1; i++) begin
        if (rxq_pop) begin
          rxq_q[i] <= rxq_q[i+1]; // see R16
        end
      end
      for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
        if (rxq_push && rxq_wp == 2'(i)) begin
          rxq_q[i] <= {rx_pe_q, rx_fe_q, rx_word_q}; // see R4
        end
      end
      rxq_cnt_q <= rxq_cnt_q + 2'(rxq_push) - 2'(rxq_pop);
    end
  end
  assign rx_data_o = rxq_q[0][7:0];

  // Sticky errors: a new error in the reset cycle survives
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pe_lat_q <= 1'b0;
      ovr_lat_q <= 1'b0;
    end else begin
      pe_lat_q <= (rxq_push && rx_pe_q) || (pe_lat_q && !error_reset_i); // see R18
      ovr_lat_q <= (rx_push_q && !rxq_push) || (ovr_lat_q && !error_reset_i); // see R4
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      line_status_reg_o <= STATUS_RST;
      rx_error_status_reg_o <= STATUS_RST;
      special_rx_o <= 1'b0;
    end else begin
      line_status_reg_o[LS_AVAIL] <= (rxq_cnt_q != 2'h0); // see R4
      line_status_reg_o[LS_TXE] <= !txf_valid; // see R1
      line_status_reg_o[LS_DCD] <= !dcd_s; // see R21
      line_status_reg_o[LS_SYNC] <= !xtal_en_i && !sync_s; // see R19
      line_status_reg_o[LS_CTS] <= !cts_s; // see R10
      line_status_reg_o[LS_BRK] <= rx_brk_q; // see R22
      rx_error_status_reg_o[ES_ALL_SENT] <= all_sent_q; // see R12
      rx_error_status_reg_o[ES_PAR] <= pe_lat_q;
      rx_error_status_reg_o[ES_OVR] <= ovr_lat_q;
      rx_error_status_reg_o[ES_FRM] <= (rxq_cnt_q != 2'h0) && rxq_q[0][8]; // see R16
      special_rx_o <= (rxq_cnt_q != 2'h0) &&
                      (rxq_q[0][8] || (irq_config_reg_i[IC_PAR_SPC] && rxq_q[0][9])); // see R18
    end
  end

  tx_empty_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R1
    !txf_valid |=> line_status_reg_o[LS_TXE])
    else $error("tx empty flag missing");
  rts_plain_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R8
    !auto_en && !rts_hold_q |=> rts_n_o == !$past(tx_config_reg_i[TC_RTS]))
    else $error("rts pin not inverse of bit");
  rts_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R9
    auto_en && $past(auto_en) && !rts_n_o && rts_hold_q && !all_sent_q |=> !rts_n_o)
    else $error("rts released before drain");
  cts_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R10
    auto_en && cts_s && tx_st_q == ST_IDLE |=> tx_st_q == ST_IDLE)
    else $error("transmit started with cts high");
  break_out_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R11
    brk_q ##1 brk_q |-> !txd_o)
    else $error("break not driving zero");
  all_sent_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R12
    rx_error_status_reg_o[ES_ALL_SENT] |-> $past(all_sent_q, 1))
    else $error("all sent set early");
  rx_avail_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R4
    rxq_push |=> (rxq_cnt_q != 2'h0) ##1 line_status_reg_o[LS_AVAIL])
    else $error("character available not set");
  overrun_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R4
    rx_push_q && rxq_cnt_q == 2'h3 && !rx_pop_i |=> ovr_lat_q ##1 rx_error_status_reg_o[ES_OVR])
    else $error("overrun not flagged");
  parity_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R18
    pe_lat_q && !error_reset_i |=> pe_lat_q)
    else $error("parity error not latched");
  sync_xtal_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see R19
    xtal_en_i |=> !line_status_reg_o[LS_SYNC])
    else $error("sync bit not forced low");

endmodule : async_serial_channel

`default_nettype wire

// file: inc/async_serial_pkg.sv
// Operation
// R1 - Transmit-empty status bit goes to 1 whenever the transmit buffer empties.
// R2 - Transmit length code: 00 five or fewer, 01 seven, 10 six, 11 eight.
// R3 - Five-or-fewer mode: leading ones, three zeros, then n right-justified data bits.
// R4 - Three-entry receive FIFO with errors; character-available flag; overrun on overflow.
// R5 - Parity enable appends one bit; sense bit 1 even, 0 odd.
// R6 - Clock factor 1x/16x/32x/64x shared; only 1x allows non-NRZ encodings.
// R7 - Software never picks one-and-a-half stop bits at 1x; two bits only.
// R8 - Without auto-enables, request-to-send pin is the inverse of its bit.
// R9 - Auto-enables: pin low at once; held low until transmitter fully drained.
// R10 - Clear-to-send shown in status; with auto-enables high level stops transmitter.
// R11 - Break sends zeros, starting and stopping on bit-boundary clock edges.
// R12 - All-sent set only when transmitter empty and stop bit left the pin.
// R13 - Software programs all formats before enabling transmitter or receiver.
// R14 - Receiver length comes from receive configuration bits 7:6.
// R15 - One stop bit checked; a zero sets framing error at push time.
// R16 - Framing error travels with its character, visible only at FIFO head.
// R17 - Received parity bit stored beside data when both fit in eight bits.
// R18 - Parity error special condition gated by enable bit; latched until error reset.
// R19 - Sync input level in sync/hunt bit; forced 0 with crystal oscillator.
// R20 - Terminal-ready pin is inverse of its bit unless carrying DMA request.
// R21 - Carrier detect shown in status; with auto-enables high level stops receiver.
// R22 - Null with framing error sets break until a one; one clean null kept.
// R23 - Stop field other than 00 selects asynchronous mode for both directions.
// R24 - Oversampled receiver confirms start at half bit, samples bit centres.
package async_serial_pkg;

  // Mode/format register fields
  localparam int MF_PAR_EN = 0;
  localparam int MF_PAR_EVEN = 1;
  localparam int MF_STOP_LO = 2;
  localparam int MF_CF_LO = 6;
  // Transmit configuration fields
  localparam int TC_RTS = 1;
  localparam int TC_TX_EN = 3;
  localparam int TC_BRK = 4;
  localparam int TC_LEN_LO = 5;
  localparam int TC_DTR = 7;
  // Receive configuration fields
  localparam int RC_RX_EN = 0;
  localparam int RC_AUTO = 5;
  localparam int RC_LEN_LO = 6;
  // Interrupt configuration fields
  localparam int IC_PAR_SPC = 2;
  // Line status bits
  localparam int LS_AVAIL = 0;
  localparam int LS_TXE = 2;
  localparam int LS_DCD = 3;
  localparam int LS_SYNC = 4;
  localparam int LS_CTS = 5;
  localparam int LS_BRK = 7;
  // Receive error status bits
  localparam int ES_ALL_SENT = 0;
  localparam int ES_PAR = 4;
  localparam int ES_OVR = 5;
  localparam int ES_FRM = 6;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [1:0] STOP_SYNC = 2'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;
  localparam int TX_FIFO_DEPTH = 8;
  localparam int RX_FIFO_DEPTH = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP = 3'h6
  } ser_state_t;

  function automatic logic [7:0] factor_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: return 8'h01;
      2'h1: return 8'h10;
      2'h2: return 8'h20;
      default: return 8'h40;
    endcase
  endfunction : factor_cycles

  function automatic logic [3:0] len_bits(input logic [1:0] code);
    case (code)
      2'h0: return 4'h5;
      2'h1: return 4'h7;
      2'h2: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction : len_bits

  function automatic logic [7:0] len_mask(input logic [3:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (4'(i) < n);
    end
    return m;
  endfunction : len_mask

endpackage : async_serial_pkg

// file: sim/async_serial_channel_bench.sv
`timescale 1ns/100ps
`default_nettype none

module async_serial_channel_bench;
  import async_serial_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] mf = 8'h44, tc = 8'h00, rc = 8'h00, ic = 8'h04, tx_data = 8'h00;
  logic xtal = 1'b0, dsel = 1'b0, erst = 1'b0, tx_valid = 1'b0, pop = 1'b0;
  logic cts_n = 1'b0, dcd_n = 1'b0, sync_n = 1'b1;
  logic tx_ready, special, txd, rxd, rts_n, dtr_n;
  logic [7:0] rx_data, ls, es;
  logic [3:0] nb = 4'h8;
  logic [1:0] lc [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [7:0] tb_byte [4] = '{8'hA5, 8'h5A, 8'h2C, 8'hE2};
  int tb_n [4] = '{8, 7, 6, 2};
  int n_mismatch = 0, check_count = 0;
  initial forever #20 mclk_i = ~mclk_i;
  async_serial_channel u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .mode_format_reg_i(mf),
    .tx_config_reg_i(tc), .rx_config_reg_i(rc), .irq_config_reg_i(ic), .xtal_en_i(xtal),
    .dma_req_sel_i(dsel), .error_reset_i(erst), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_pop_i(pop), .line_status_reg_o(ls),
    .rx_error_status_reg_o(es), .special_rx_o(special), .txd_o(txd), .rxd_i(rxd),
    .cts_n_i(cts_n), .carrier_detect_pin_n_i(dcd_n), .sync_n_i(sync_n), .rts_n_o(rts_n),
    .dtr_req_n_o(dtr_n));
  remote_term u_term (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd), .nbits_i(nb));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  task automatic fail();
    n_mismatch++;
    $display("MISMATCH t=%0t wait ran out", $time);
    results();
  endtask : fail
  // Valid is dropped for a cycle so back-to-back calls never merge into one pulse
  task automatic put(input logic [7:0] d);
    int k;
    k = 0;
    while (tx_ready !== 1'b1) begin
      tick(1);
      k++;
      if (k > 2000) fail();
    end
    tx_data = d;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask : put
  task automatic take();
    pop = 1'b1;
    tick(1);
    pop = 1'b0;
    tick(3);
  endtask : take
  task automatic wait_ls(input int b, input logic v);
    int k;
    k = 0;
    while (ls[b] !== v) begin
      tick(1);
      k++;
      if (k > 400) fail();
    end
  endtask : wait_ls
  task automatic wait_cap(input logic [9:0] exp);
    int k;
    k = 0;
    while (u_term.cap_q.size() == 0) begin
      tick(1);
      k++;
      if (k > 600) fail();
    end
    chk(u_term.cap_q.pop_front(), exp);
  endtask : wait_cap
  function automatic logic [9:0] frame(input logic [7:0] d, input int n, input logic par,
                                       input logic even);
    logic [9:0] f;
    f = 10'(d) & ((10'h001 << n) - 10'h001);
    if (par) begin
      f[n] = (^f) ^ !even;
    end
    f[n + par] = 1'b1;
    return f;
  endfunction : frame

  initial begin
    tick(8);
    rst_i = 1'b0;
    tick(2);
    chk(10'({txd, rts_n, ls[LS_TXE], es[ES_ALL_SENT]}), 10'h00F);
    for (int i = 0; i < 4; i++) begin
      cts_n = i[0];
      dcd_n = i[1];
      sync_n = !i[0];
      xtal = i[1];
      tc = {i[1], 5'h00, i[0], 1'b0};
      tick(6);
      chk(10'({rts_n, dtr_n, ls[LS_CTS], ls[LS_DCD], ls[LS_SYNC]}),
          10'({!i[0], !i[1], !i[0], !i[1], i[0] & !i[1]}));
    end
    dsel = 1'b1;
    tick(4);
    chk(10'(dtr_n), 10'h000);
    dsel = 1'b0;
    {cts_n, dcd_n, xtal} = 3'b000;
    for (int k = 0; k < 4; k++) begin
      mf = k[0] ? 8'h47 : 8'h45;
      tick(1);
      tc = {1'b0, lc[k], 5'h08};
      nb = 4'(tb_n[k] + 1);
      tick(2);
      put(tb_byte[k]);
      tick(20);
      chk(10'(es[ES_ALL_SENT]), 10'h000);
      wait_cap(frame(tb_byte[k], tb_n[k], 1'b1, k[0]));
      tick(24);
      chk(10'({ls[LS_TXE], es[ES_ALL_SENT]}), 10'h003);
    end
    mf = 8'h44;
    rc = 8'hC0;
    tick(1);
    rc = 8'hC1;
    u_term.send(9'h05A, 8, 1'b1, 1'b1);
    wait_ls(LS_AVAIL, 1'b1);
    chk(10'({rx_data, es[ES_FRM], special}), 10'h168);
    take();
    mf = 8'h47;
    rc = 8'h41;
    u_term.send(9'h031, 8, 1'b1, 1'b1);
    wait_ls(LS_AVAIL, 1'b1);
    chk(10'({rx_data, es[ES_PAR], special}), 10'h0C7);
    take();
    chk(10'({es[ES_PAR], special}), 10'h002);
    erst = 1'b1;
    tick(1);
    erst = 1'b0;
    tick(2);
    chk(10'(es[ES_PAR]), 10'h000);
    mf = 8'h44;
    rc = 8'hC1;
    u_term.send(9'h081, 8, 1'b0, 1'b1);
    wait_ls(LS_AVAIL, 1'b1);
    chk(10'({rx_data, es[ES_FRM], special}), 10'h207);
    take();
    chk(10'({es[ES_FRM], special}), 10'h000);
    for (int v = 1; v < 5; v++) u_term.send(9'(v), 8, 1'b1, 1'b1);
    tick(4);
    chk(10'(es[ES_OVR]), 10'h001);
    for (int v = 1; v < 4; v++) begin
      chk(10'(rx_data), 10'(v));
      take();
    end
    chk(10'(ls[LS_AVAIL]), 10'h000);
    erst = 1'b1;
    tick(1);
    erst = 1'b0;
    u_term.send(9'h000, 8, 1'b0, 1'b0);
    tick(40);
    chk(10'({ls[LS_BRK], ls[LS_AVAIL], rx_data}), 10'h300);
    chk(10'(es[ES_FRM]), 10'h000);
    u_term.level(1'b1);
    tick(40);
    chk(10'(ls[LS_BRK]), 10'h000);
    take();
    chk(10'(ls[LS_AVAIL]), 10'h000);
    rc = 8'hE1;
    dcd_n = 1'b1;
    u_term.send(9'h033, 8, 1'b1, 1'b1);
    tick(4);
    chk(10'(ls[LS_AVAIL]), 10'h000);
    dcd_n = 1'b0;
    cts_n = 1'b1;
    nb = 4'h8;
    tc = 8'h6A;
    tick(2);
    chk(10'(rts_n), 10'h000);
    for (int j = 0; j < TX_FIFO_DEPTH; j++) put(8'(j + 16));
    tx_data = 8'hFF;
    tx_valid = 1'b1;
    tick(2);
    chk(10'(tx_ready), 10'h000);
    tx_valid = 1'b0;
    tick(100);
    chk(10'(u_term.cap_q.size()), 10'h000);
    tc = 8'h68;
    tick(4);
    chk(10'(rts_n), 10'h000);
    cts_n = 1'b0;
    // The refused write must not appear after the eighth frame
    for (int j = 0; j < TX_FIFO_DEPTH; j++) wait_cap(frame(8'(j + 16), 8, 1'b0, 1'b0));
    chk(10'(rts_n), 10'h000);
    tick(24);
    chk(10'({rts_n, es[ES_ALL_SENT], u_term.cap_q.size() == 0}), 10'h007);
    tc = 8'h78;
    tick(20);
    chk(10'(txd), 10'h000);
    tc = 8'h68;
    tick(20);
    chk(10'(txd), 10'h001);
    tick(200);
    results();
  end
endmodule : async_serial_channel_bench

`default_nettype wire

// file: sim/remote_term.sv
`timescale 1ns/100ps
`default_nettype none

module remote_term (
  // Clock
  input wire logic mclk_i,
  // Serial line
  input wire logic txd_i,
  output logic rxd_o,
  // Data plus parity bits per frame
  input wire logic [3:0] nbits_i
);
  localparam int BITC = 16;
  logic [9:0] cap_q[$];
  logic [9:0] sh;
  initial rxd_o = 1'b1;
  task automatic level(input logic v);
    rxd_o = v;
  endtask : level
  // Stop and idle levels are chosen so faults can be sent
  task automatic send(input logic [8:0] b, input int n, input logic stop, input logic idl);
    rxd_o = 1'b0;
    repeat (BITC) @(negedge mclk_i);
    for (int i = 0; i <= n; i++) begin
      rxd_o = (i == n) ? stop : b[i];
      repeat (BITC) @(negedge mclk_i);
    end
    rxd_o = idl;
    repeat (BITC) @(negedge mclk_i);
  endtask : send
  // Cell centres are sampled; the stop bit lands above the data
  always begin
    @(negedge txd_i);
    repeat (BITC / 2) @(posedge mclk_i);
    if (txd_i == 1'b0) begin
      sh = '0;
      for (int i = 0; i <= nbits_i; i++) begin
        repeat (BITC) @(posedge mclk_i);
        sh[i] = txd_i;
      end
      cap_q.push_back(sh);
    end
  end
endmodule : remote_term

`default_nettype wire
